// ===== ext_irq_pkg.sv
package ext_irq_pkg;

  localparam int        ADDR_W          = 8;
  localparam int        DATA_W          = 32;
  localparam int        NUM_LINES       = 5;

  localparam logic [7:0] SENSE_CTRL_OFS = 8'h28;
  localparam logic [7:0] STATUS_OFS     = 8'h2c;
  localparam logic [7:0] MASK_OFS       = 8'h30;

  localparam logic [7:0] SENSE_CTRL_RST = 8'h00;
  localparam logic [4:0] STATUS_RST     = 5'h00;
  localparam logic [4:0] MASK_RST       = 5'h00;

  localparam int PORTB_FIELD_HI   = 7;
  localparam int PORTB_FIELD_LO   = 6;
  localparam int PORTB_INV_BIT    = 5;
  localparam int PORTA_FIELD_HI   = 4;
  localparam int PORTA_FIELD_LO   = 3;
  localparam int PORTA_INV_BIT    = 2;
  localparam int TOP_EDGE_BIT     = 1;
  localparam int TOP_ENABLE_BIT   = 0;

  localparam int LINE_PORTA_LOW   = 0;
  localparam int LINE_PORTF_LOW   = 1;
  localparam int LINE_PORTB_LOW   = 2;
  localparam int LINE_PORTB_HIGH  = 3;
  localparam int LINE_TOP         = 4;

  localparam logic [1:0] MODE_EDGE_LEVEL = 2'h0;
  localparam logic [1:0] MODE_RISE       = 2'h1;
  localparam logic [1:0] MODE_FALL       = 2'h2;
  localparam logic [1:0] MODE_BOTH       = 2'h3;

  localparam logic [1:0] LEVEL_MASKED    = 2'h3;

endpackage : ext_irq_pkg

// ===== external_irq_sensitivity_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module external_irq_sensitivity_ctrl
  import ext_irq_pkg::*;
#(
  parameter int SYNC_STAGES = 2
)
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [ADDR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [DATA_W-1:0]   wb_dat_i,
  output logic      [DATA_W-1:0]   wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                ext_line_porta_low_i,
  input  wire logic                ext_line_portf_low_i,
  input  wire logic                ext_line_portb_low_i,
  input  wire logic                ext_line_portb_high_i,
  input  wire logic                top_level_irq_i,
  input  wire logic                irq_level_bit_hi_i,
  input  wire logic                irq_level_bit_lo_i,
  output logic                     irq_o
);

  logic [7:0]            ext_irq_sense_control;
  logic [7:0]            next_ext_irq_sense_control;
  logic [4:0]            status;
  logic [4:0]            next_status;
  logic [4:0]            mask;
  logic [4:0]            next_mask;
  logic                  next_ack;
  logic [DATA_W-1:0]     next_dat;
  logic                  next_irq;

  logic [NUM_LINES-1:0]  pins;
  logic [NUM_LINES-1:0]  sync      [SYNC_STAGES];
  logic [NUM_LINES-1:0]  next_sync [SYNC_STAGES];
  logic [NUM_LINES-1:0]  prev;
  logic [NUM_LINES-1:0]  next_prev;
  logic [NUM_LINES-1:0]  event_hit;
  logic [1:0]            line_mode [NUM_LINES-1:0];
  logic [NUM_LINES-1:0]  line_inv;

  logic                  bus_req;
  logic                  wr_ctrl;
  logic                  wr_status;
  logic                  wr_mask;
  logic                  level3;
  logic                  group_changed;

  assign pins = {top_level_irq_i, ext_line_portb_high_i,
                 ext_line_portb_low_i, ext_line_portf_low_i,
                 ext_line_porta_low_i};

  // per-line mode and inversion selection
  always_comb
  begin
    line_mode[LINE_PORTB_LOW]  = ext_irq_sense_control[PORTB_FIELD_HI:
                                                        PORTB_FIELD_LO];
    line_mode[LINE_PORTB_HIGH] = ext_irq_sense_control[PORTB_FIELD_HI:
                                                        PORTB_FIELD_LO];
    line_mode[LINE_PORTA_LOW]  = ext_irq_sense_control[PORTA_FIELD_HI:
                                                        PORTA_FIELD_LO];
    line_mode[LINE_PORTF_LOW]  = ext_irq_sense_control[PORTA_FIELD_HI:
                                                        PORTA_FIELD_LO];
    line_mode[LINE_TOP]        = ext_irq_sense_control[TOP_EDGE_BIT] ?
                                 MODE_RISE : MODE_FALL;
    line_inv[LINE_PORTB_LOW]   = ext_irq_sense_control[PORTB_INV_BIT];
    line_inv[LINE_PORTB_HIGH]  = 1'b0;
    line_inv[LINE_PORTA_LOW]   = ext_irq_sense_control[PORTA_INV_BIT];
    line_inv[LINE_PORTF_LOW]   = 1'b0;
    line_inv[LINE_TOP]         = 1'b0;
  end

  // synchroniser chain and previous sample
  always_comb
  begin
    next_sync[0] = pins;
    for (int s = 1; s < SYNC_STAGES; s++)
    begin
      next_sync[s] = sync[s-1];
    end
    next_prev = sync[SYNC_STAGES-1];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync <= '{default: '1};
      prev <= '1;
    end
    else
    begin
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  // edge and level detector per line
  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++)
    begin : g_line
      logic cur_s;
      logic prev_s;
      logic rise_s;
      logic fall_s;

      always_comb
      begin
        cur_s  = sync[SYNC_STAGES-1][g] ^ line_inv[g];
        prev_s = prev[g] ^ line_inv[g];
        rise_s = ~prev_s & cur_s;
        fall_s = prev_s & ~cur_s;
        case (line_mode[g])
          MODE_EDGE_LEVEL: event_hit[g] = fall_s | ~cur_s;
          MODE_RISE:       event_hit[g] = rise_s;
          MODE_FALL:       event_hit[g] = fall_s;
          MODE_BOTH:       event_hit[g] = rise_s | fall_s;
          default:         event_hit[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // bus decode
  always_comb
  begin
    bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wr_ctrl   = bus_req & wb_we_i & wb_sel_i[0] &
                (wb_adr_i[ADDR_W-1:2] == SENSE_CTRL_OFS[ADDR_W-1:2]);
    wr_status = bus_req & wb_we_i & wb_sel_i[0] &
                (wb_adr_i[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2]);
    wr_mask   = bus_req & wb_we_i & wb_sel_i[0] &
                (wb_adr_i[ADDR_W-1:2] == MASK_OFS[ADDR_W-1:2]);
    level3    = ({irq_level_bit_hi_i, irq_level_bit_lo_i} == LEVEL_MASKED);
  end

  // control next value
  always_comb
  begin
    next_ext_irq_sense_control = ext_irq_sense_control;
    group_changed              = 1'b0;
    if (wr_ctrl)
    begin
      if (level3)
      begin
        next_ext_irq_sense_control[7:2] = wb_dat_i[7:2];
      end
      if (!ext_irq_sense_control[TOP_ENABLE_BIT])
      begin
        next_ext_irq_sense_control[TOP_EDGE_BIT] =
          wb_dat_i[TOP_EDGE_BIT];
      end
      next_ext_irq_sense_control[TOP_ENABLE_BIT] =
        wb_dat_i[TOP_ENABLE_BIT];
      group_changed = level3 &
        (wb_dat_i[7:2] != ext_irq_sense_control[7:2]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_irq_sense_control <= SENSE_CTRL_RST;
    end
    else
    begin
      ext_irq_sense_control <= next_ext_irq_sense_control;
    end
  end

  // mask next value
  always_comb
  begin
    next_mask = mask;
    if (wr_mask)
    begin
      next_mask = wb_dat_i[4:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask <= MASK_RST;
    end
    else
    begin
      mask <= next_mask;
    end
  end

  // sticky status, a new event wins over a clear
  always_comb
  begin
    next_status = status;
    if (wr_status)
    begin
      next_status = next_status & ~wb_dat_i[4:0];
    end
    if (group_changed)
    begin
      next_status[3:0] = 4'h0;
    end
    next_status[3:0] = next_status[3:0] | event_hit[3:0];
    next_status[LINE_TOP] = next_status[LINE_TOP] |
      (event_hit[LINE_TOP] & ext_irq_sense_control[TOP_ENABLE_BIT]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status <= STATUS_RST;
    end
    else
    begin
      status <= next_status;
    end
  end

  // level interrupt from unmasked status
  always_comb
  begin
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= next_irq;
    end
  end

  // read data and acknowledge
  always_comb
  begin
    next_ack = bus_req;
    next_dat = '0;
    if (bus_req && !wb_we_i)
    begin
      case (wb_adr_i[ADDR_W-1:2])
        SENSE_CTRL_OFS[ADDR_W-1:2]: next_dat[7:0] = ext_irq_sense_control;
        STATUS_OFS[ADDR_W-1:2]:     next_dat[4:0] = status;
        MASK_OFS[ADDR_W-1:2]:       next_dat[4:0] = mask;
        default:                    next_dat      = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= next_ack;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= '0;
    end
    else
    begin
      wb_dat_o <= next_dat;
    end
  end

endmodule : external_irq_sensitivity_ctrl

`default_nettype wire

// ===== ext_irq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ext_irq_chk
  import ext_irq_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic [DATA_W-1:0] wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              ext_line_porta_low_i,
  input wire logic              ext_line_portb_low_i,
  input wire logic              top_level_irq_i,
  input wire logic              irq_level_bit_hi_i,
  input wire logic              irq_level_bit_lo_i,
  input wire logic              irq_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [7:0] ctl, next_ctl;
  logic [4:0] msk, next_msk;
  wire        take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr   = take & wb_we_i & wb_sel_i[0];
  wire        at_c = wb_adr_i[7:2] == SENSE_CTRL_OFS[7:2];
  always_comb
  begin
    next_ctl = ctl;
    next_msk = msk;
    if (wr && at_c)
    begin
      if (irq_level_bit_hi_i && irq_level_bit_lo_i)
        next_ctl[7:2] = wb_dat_i[7:2];
      if (!ctl[0])
        next_ctl[1] = wb_dat_i[1];
      next_ctl[0] = wb_dat_i[0];
    end
    if (wr && wb_adr_i[7:2] == MASK_OFS[7:2])
      next_msk = wb_dat_i[4:0];
  end
  always_ff @(posedge clk_i)
  begin
    ctl <= rst_i ? SENSE_CTRL_RST : next_ctl;
    msk <= rst_i ? MASK_RST : next_msk;
  end
  ack_once_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_delay_a:
    assert property (take |=> wb_ack_o) else $error("ack missing");
  dat_idle_a:
    assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("data idle");
  ctl_read_a:
    assert property (take && !wb_we_i && at_c |=> wb_dat_o[7:0] == ctl)
    else $error("control readback");
  level_req_a:
    assert property ((msk[0] && ctl[4:2] == 3'h0 && !ext_line_porta_low_i)
      [*4] |=> irq_o) else $error("level request");
  top_rise_a:
    assert property (ctl[1:0] == 2'h3 && msk[4] && !top_level_irq_i ##1
      top_level_irq_i [*4] |=> irq_o) else $error("top rise");
  both_edge_a:
    assert property (ctl[7:5] == 3'h7 && msk[2] && ext_line_portb_low_i ##1
      !ext_line_portb_low_i [*4] |=> irq_o) else $error("both edges");
  irq_off_a:
    assert property (msk == 5'h00 |-> !irq_o) else $error("masked irq");
endmodule : ext_irq_chk
bind external_irq_sensitivity_ctrl ext_irq_chk watch (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .ext_line_porta_low_i, .ext_line_portb_low_i,
  .top_level_irq_i, .irq_level_bit_hi_i, .irq_level_bit_lo_i, .irq_o);
`default_nettype wire

// ===== pin_src.sv
`timescale 1ns/1ps
`default_nettype none
module pin_src
(
  output logic [4:0] pin_o
);
  initial pin_o = 5'h1f;
  task put(input logic [4:0] v);
    pin_o <= v;
  endtask : put
endmodule : pin_src
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ext_irq_pkg::*;
;
  logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, hi, lo;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [DATA_W-1:0] wb_dat_i, wb_dat_o, q;
  logic              wb_ack_o, irq_o;
  logic [4:0]        p;
  int                err_count, n_checks, n;
  pin_src pins (.pin_o(p));
  external_irq_sensitivity_ctrl DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .ext_line_porta_low_i(p[0]), .ext_line_portf_low_i(p[1]),
    .ext_line_portb_low_i(p[2]), .ext_line_portb_high_i(p[3]),
    .top_level_irq_i(p[4]), .irq_level_bit_hi_i(hi),
    .irq_level_bit_lo_i(lo), .irq_o);
  always #2.5 clk_i = ~clk_i;
  task end_sim;
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task chk(input string s, input logic [31:0] g, x);
    n_checks++;
    if (g !== x)
    begin
      $display("wrong value %s exp %h got %h", s, x, g);
      err_count++;
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 9);
    q = wb_dat_o;
    if (wb_ack_o !== 1'b1)
    begin
      err_count++;
      end_sim();
    end
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : bus
  task rd(input string s, input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(s, q, x);
  endtask : rd
  task wt;
    repeat (6) @(posedge clk_i);
  endtask : wt
  task grp(input logic g, i, input logic [1:0] m);
    logic [1:0] f, r;
    logic [4:0] x;
    int         sh;
    f = {m == 2'h3 || !m[0], m == 2'h3 || m[0] == i} | {2{m == 2'h0}};
    r = {m == 2'h3 || m[0], m == 2'h3 || m[0] != i} | {2{m == 2'h0}};
    x = g ? 5'h03 : 5'h0c;
    sh = g ? 0 : 2;
    bus(1'b1, SENSE_CTRL_OFS, g ? {27'h0, m, i, 2'h0} : {24'h0, m, i, 5'h0});
    bus(1'b1, STATUS_OFS, 32'h1f);
    rd("level", STATUS_OFS, {31'h0, m == 2'h0 && i} << sh);
    pins.put(p & ~x);
    wt;
    rd("fall", STATUS_OFS, {30'h0, f} << sh);
    chk("irq", {31'h0, irq_o}, {31'h0, |f});
    bus(1'b1, STATUS_OFS, 32'h1f);
    pins.put(p | x);
    wt;
    rd("rise", STATUS_OFS, {30'h0, r} << sh);
    bus(1'b1, STATUS_OFS, 32'h1f);
  endtask : grp
  initial
  begin
    {clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, hi, lo} = 7'h20;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("ctl", SENSE_CTRL_OFS, 32'h0);
    rd("unmapped", 8'h3c, 32'h0);
    bus(1'b1, SENSE_CTRL_OFS, 32'hff);
    rd("gate", SENSE_CTRL_OFS, 32'h3);
    bus(1'b1, SENSE_CTRL_OFS, 32'h0);
    rd("lock", SENSE_CTRL_OFS, 32'h2);
    wb_sel_i <= 4'he;
    bus(1'b1, SENSE_CTRL_OFS, 32'h01);
    wb_sel_i <= 4'h1;
    rd("no sel", SENSE_CTRL_OFS + 8'h3, 32'h2);
    {hi, lo} <= 2'b11;
    bus(1'b1, MASK_OFS, 32'h1f);
    for (int g = 0; g < 2; g++)
      for (int m = 0; m < 4; m++)
        for (int i = 0; i < 2; i++)
          grp(g[0], i[0], m[1:0]);
    bus(1'b1, SENSE_CTRL_OFS, 32'h3);
    pins.put(5'h0f);
    wt;
    rd("top fall", STATUS_OFS, 32'h0);
    pins.put(5'h1f);
    wt;
    rd("top rise", STATUS_OFS, 32'h10);
    bus(1'b1, MASK_OFS, 32'h0);
    chk("masked", {31'h0, irq_o}, 32'h0);
    bus(1'b1, MASK_OFS, 32'h1f);
    chk("unmasked", {31'h0, irq_o}, 32'h1);
    bus(1'b1, SENSE_CTRL_OFS, 32'h0);
    bus(1'b1, STATUS_OFS, 32'h1f);
    pins.put(5'h0f);
    wt;
    pins.put(5'h1f);
    wt;
    rd("top off", STATUS_OFS, 32'h0);
    bus(1'b1, SENSE_CTRL_OFS, 32'h10);
    pins.put(5'h1d);
    wt;
    pins.put(5'h1f);
    bus(1'b1, SENSE_CTRL_OFS, 32'h10);
    rd("same", STATUS_OFS, 32'h2);
    {hi, lo} <= 2'b01;
    bus(1'b1, SENSE_CTRL_OFS, 32'h08);
    rd("gated", STATUS_OFS, 32'h2);
    rd("gated ctl", SENSE_CTRL_OFS, 32'h10);
    {hi, lo} <= 2'b11;
    bus(1'b1, SENSE_CTRL_OFS, 32'h08);
    rd("cleared", STATUS_OFS, 32'h0);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
